// *** hw/dsprf_mem.sv ***
`timescale 1ns/1ns
module dsprf_mem
	import dsprf_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_we0,
	input wire logic [AW-1:0] i_wa0,
	input wire logic [DW-1:0] i_wd0,
	input wire logic i_we1,
	input wire logic [AW-1:0] i_wa1,
	input wire logic [DW-1:0] i_wd1,
	input wire logic i_we2,
	input wire logic [AW-1:0] i_wa2,
	input wire logic [DW-1:0] i_wd2,
	input wire logic i_we3,
	input wire logic [AW-1:0] i_wa3,
	input wire logic [DW-1:0] i_wd3,
	input wire logic [AW-1:0] i_rxa,
	input wire logic [AW-1:0] i_rya,
	output logic [DW-1:0] o_rx,
	output logic [DW-1:0] o_ry,
	input wire logic [AW-1:0] i_ca,
	output logic [DW-1:0] o_c,
	input wire logic [AW-1:0] i_dsa,
	output logic [DW-1:0] o_ds,
	input wire logic [AW-1:0] i_psa,
	output logic [DW-1:0] o_ps
);
	logic [DW-1:0] mem_ff [2*NREG];
	logic [DW-1:0] nxt_mem [2*NREG];
	logic [DW-1:0] rx_ff, ry_ff;
	logic [DW-1:0] rx_old;

	// ----------------------------------------
	// Write merge, lowest precedence first
	// ----------------------------------------
	always_comb begin
		for (int k = 0; k < 2*NREG; k++) begin
			nxt_mem[k] = mem_ff[k];
		end
		if (i_we3) nxt_mem[i_wa3] = i_wd3;
		if (i_we2) nxt_mem[i_wa2] = i_wd2;
		if (i_we1) nxt_mem[i_wa1] = i_wd1;
		if (i_we0) nxt_mem[i_wa0] = i_wd0;
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			for (int k = 0; k < 2*NREG; k++) begin
				mem_ff[k] <= REG_RST;
			end
			rx_ff <= REG_RST;
			ry_ff <= REG_RST;
		end else begin
			mem_ff <= nxt_mem;
			// Read samples the old contents at the same edge as the write
			rx_ff <= mem_ff[i_rxa];
			ry_ff <= mem_ff[i_rya];
		end
	end

	assign rx_old = mem_ff[i_rxa];
	assign o_rx = rx_ff;
	assign o_ry = ry_ff;
	assign o_c = mem_ff[i_ca];
	// Store reads; the bus side registers them before they leave the block
	assign o_ds = mem_ff[i_dsa];
	assign o_ps = mem_ff[i_psa];

	move_beats_cmp_a: assert property (@(posedge i_clk) disable iff (i_srst)
		i_we2 && i_we3 && (i_wa2 == i_wa3) && !i_we0 && !i_we1
		|=> mem_ff[$past(i_wa2)] == $past(i_wd2))
		else $error("compute write overrode a move");
	read_old_a: assert property (@(posedge i_clk) disable iff (i_srst)
		i_we3 && (i_wa3 == i_rxa) |=> o_rx == $past(rx_old))
		else $error("operand read did not see old value");
endmodule

// *** hw/dsprf_pkg.sv ***
package dsprf_pkg;
	// ----------------------------------------
	// Geometry
	// ----------------------------------------
	localparam int unsigned DW = 16;
	localparam int unsigned NREG = 16;
	localparam int unsigned IW = 4;
	localparam int unsigned AW = 5;
	localparam int unsigned MSR_W = 7;
	localparam logic [MSR_W-1:0] MSR_RST = 7'h00;
	localparam int unsigned BANK_BIT = 0;
	localparam logic [DW-1:0] REG_RST = 16'h0000;

	// ----------------------------------------
	// Register indices inside a bank
	// ----------------------------------------
	localparam logic [IW-1:0] R_ALU_X0 = 4'h0;
	localparam logic [IW-1:0] R_ALU_X1 = 4'h1;
	localparam logic [IW-1:0] R_ALU_Y0 = 4'h2;
	localparam logic [IW-1:0] R_ALU_Y1 = 4'h3;
	localparam logic [IW-1:0] R_MAC_X0 = 4'h4;
	localparam logic [IW-1:0] R_MAC_X1 = 4'h5;
	localparam logic [IW-1:0] R_MAC_Y0 = 4'h6;
	localparam logic [IW-1:0] R_MAC_Y1 = 4'h7;
	localparam logic [IW-1:0] R_MAC_R0 = 4'h8;
	localparam logic [IW-1:0] R_MAC_R1 = 4'h9;
	localparam logic [IW-1:0] R_MAC_R2 = 4'ha;
	localparam logic [IW-1:0] R_SHR_0 = 4'hb;
	localparam logic [IW-1:0] R_SHR_1 = 4'hc;
	localparam logic [IW-1:0] R_SHIFT_RESULT_UPPER = 4'hd;
	localparam logic [IW-1:0] R_ALU_RES = 4'he;
	localparam logic [IW-1:0] R_SHIFT_IN = 4'hf;
	localparam logic [IW-1:0] R_OPND_LAST = 4'h7;

	typedef enum logic [1:0] {
		UNIT_ALU,
		UNIT_MAC,
		UNIT_SHIFT
	} dsprf_unit_t;
endpackage

// *** hw/dsprf_top.sv ***
`timescale 1ns/1ns
module dsprf_top
	import dsprf_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_msr_we,
	input wire logic [MSR_W-1:0] i_msr_wdata,
	input wire logic i_mode_set,
	input wire logic i_mode_clr,
	input wire logic [MSR_W-1:0] i_mode_mask,
	output logic [MSR_W-1:0] o_mode_status_reg,
	output logic o_alt_bank_select,
	input wire logic i_cmp_we,
	input wire dsprf_unit_t i_unit,
	input wire logic i_cond,
	input wire logic i_cond_true,
	input wire logic i_multi,
	input wire logic [IW-1:0] i_xsel,
	input wire logic [IW-1:0] i_ysel,
	input wire logic [IW-1:0] i_cmp_dst,
	input wire logic [DW-1:0] i_cmp_data,
	output logic [DW-1:0] o_xop,
	output logic [DW-1:0] o_yop,
	input wire logic i_mov_en,
	input wire logic [IW-1:0] i_mov_dst,
	input wire logic [IW-1:0] i_mov_src,
	input wire logic i_dual,
	input wire logic i_dm_en,
	input wire logic i_dm_ld,
	input wire logic [IW-1:0] i_dm_reg,
	input wire logic [DW-1:0] i_data_memory_bus,
	output logic [DW-1:0] o_data_memory_bus,
	output logic o_dm_valid,
	input wire logic i_pm_en,
	input wire logic i_pm_ld,
	input wire logic [IW-1:0] i_pm_reg,
	input wire logic [DW-1:0] i_program_memory_bus,
	output logic [DW-1:0] o_program_memory_bus,
	output logic o_pm_valid,
	output logic o_op_err
);
	// ----------------------------------------
	// Operand legality
	// ----------------------------------------
	function automatic logic opnd_ok(input dsprf_unit_t unit, input logic is_x,
		input logic restr, input logic [IW-1:0] idx);
		logic ok;
		ok = 1'b1;
		if (unit != UNIT_SHIFT && idx == R_SHIFT_RESULT_UPPER) begin
			ok = 1'b0;
		end else if (restr) begin
			case (unit)
				UNIT_ALU: ok = is_x ? !(idx inside {R_ALU_Y0, R_ALU_Y1, R_MAC_X0, R_MAC_X1,
					R_MAC_Y0, R_MAC_Y1}) : (idx inside {R_ALU_Y0, R_ALU_Y1});
				UNIT_MAC: ok = is_x ? !(idx inside {R_ALU_X0, R_ALU_X1, R_ALU_Y0, R_ALU_Y1,
					R_MAC_Y0, R_MAC_Y1}) : (idx inside {R_MAC_Y0, R_MAC_Y1});
				UNIT_SHIFT: ok = is_x ? (idx inside {R_SHIFT_IN, R_ALU_RES, R_MAC_R0, R_MAC_R1,
					R_MAC_R2, R_SHR_0, R_SHR_1}) : 1'b1;
				default: ok = 1'b0;
			endcase
		end
		return ok;
	endfunction

	// ----------------------------------------
	// Bank selection
	// ----------------------------------------
	logic [MSR_W-1:0] msr_ff, nxt_msr;
	logic alt_bank_ff, nxt_alt_bank;

	always_comb begin
		nxt_msr = msr_ff;
		nxt_alt_bank = alt_bank_ff;
		if (i_mode_set) begin
			nxt_msr = msr_ff | i_mode_mask;
			nxt_alt_bank = nxt_msr[BANK_BIT];
		end else if (i_mode_clr) begin
			nxt_msr = msr_ff & ~i_mode_mask;
			nxt_alt_bank = nxt_msr[BANK_BIT];
		end else begin
			if (i_msr_we) begin
				nxt_msr = i_msr_wdata;
			end
			// Stored bit reaches the decoders one edge after it lands
			nxt_alt_bank = msr_ff[BANK_BIT];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			msr_ff <= MSR_RST;
			alt_bank_ff <= 1'b0;
		end else begin
			msr_ff <= nxt_msr;
			alt_bank_ff <= nxt_alt_bank;
		end
	end

	assign o_mode_status_reg = msr_ff;
	assign o_alt_bank_select = alt_bank_ff;

	// ----------------------------------------
	// Write qualification
	// ----------------------------------------
	logic restr, x_ok, y_ok, cmp_bad, cmp_we_eff;
	logic dm_bad, pm_bad, dm_we_eff, pm_we_eff;
	logic [AW-1:0] dm_wa, pm_wa, mov_wa, cmp_wa;
	logic [DW-1:0] mov_data;

	assign restr = i_cond | i_multi;
	assign x_ok = opnd_ok(i_unit, 1'b1, restr, i_xsel);
	assign y_ok = opnd_ok(i_unit, 1'b0, restr, i_ysel);
	assign cmp_bad = i_cmp_we && !(x_ok && y_ok);
	// Condition is resolved before the result is allowed to land
	assign cmp_we_eff = i_cmp_we && !cmp_bad && (!i_cond || i_cond_true);
	assign dm_bad = i_dual && i_dm_en && i_dm_ld && (i_dm_reg > R_OPND_LAST);
	assign pm_bad = i_dual && i_pm_en && i_pm_ld && (i_pm_reg > R_OPND_LAST);
	assign dm_we_eff = i_dm_en && i_dm_ld && !dm_bad;
	assign pm_we_eff = i_pm_en && i_pm_ld && !pm_bad;

	// Every address carries the live bank bit, so the idle bank is untouched
	assign dm_wa = {alt_bank_ff, i_dm_reg};
	assign pm_wa = {alt_bank_ff, i_pm_reg};
	assign mov_wa = {alt_bank_ff, i_mov_dst};
	assign cmp_wa = {alt_bank_ff, i_cmp_dst};

	logic [DW-1:0] dm_st_data, pm_st_data;

	dsprf_mem u_mem (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_we0(dm_we_eff),
		.i_wa0(dm_wa),
		.i_wd0(i_data_memory_bus),
		.i_we1(pm_we_eff),
		.i_wa1(pm_wa),
		.i_wd1(i_program_memory_bus),
		.i_we2(i_mov_en),
		.i_wa2(mov_wa),
		.i_wd2(mov_data),
		.i_we3(cmp_we_eff),
		.i_wa3(cmp_wa),
		.i_wd3(i_cmp_data),
		.i_rxa({alt_bank_ff, i_xsel}),
		.i_rya({alt_bank_ff, i_ysel}),
		.o_rx(o_xop),
		.o_ry(o_yop),
		.i_ca({alt_bank_ff, i_mov_src}),
		.o_c(mov_data),
		.i_dsa({alt_bank_ff, i_dm_reg}),
		.o_ds(dm_st_data),
		.i_psa({alt_bank_ff, i_pm_reg}),
		.o_ps(pm_st_data)
	);

	// ----------------------------------------
	// Store path, one word per bus per cycle
	// ----------------------------------------
	logic [DW-1:0] dm_out_ff, nxt_dm_out, pm_out_ff, nxt_pm_out;
	logic dm_vld_ff, nxt_dm_vld, pm_vld_ff, nxt_pm_vld, err_ff, nxt_err;

	always_comb begin
		nxt_dm_out = dm_out_ff;
		nxt_pm_out = pm_out_ff;
		nxt_dm_vld = i_dm_en && !i_dm_ld;
		nxt_pm_vld = i_pm_en && !i_pm_ld;
		if (nxt_dm_vld) begin
			nxt_dm_out = dm_st_data;
		end
		if (nxt_pm_vld) begin
			nxt_pm_out = pm_st_data;
		end
		nxt_err = cmp_bad || dm_bad || pm_bad;
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			dm_out_ff <= REG_RST;
			pm_out_ff <= REG_RST;
			dm_vld_ff <= 1'b0;
			pm_vld_ff <= 1'b0;
			err_ff <= 1'b0;
		end else begin
			dm_out_ff <= nxt_dm_out;
			pm_out_ff <= nxt_pm_out;
			dm_vld_ff <= nxt_dm_vld;
			pm_vld_ff <= nxt_pm_vld;
			err_ff <= nxt_err;
		end
	end

	assign o_data_memory_bus = dm_out_ff;
	assign o_program_memory_bus = pm_out_ff;
	assign o_dm_valid = dm_vld_ff;
	assign o_pm_valid = pm_vld_ff;
	assign o_op_err = err_ff;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	mode_imm_a: assert property (@(posedge i_clk) disable iff (i_srst)
		i_mode_set && i_mode_mask[BANK_BIT] |=> o_alt_bank_select)
		else $error("mode enable did not switch bank at once");
	msr_delay_a: assert property (@(posedge i_clk) disable iff (i_srst)
		i_msr_we && !i_mode_set && !i_mode_clr ##1 !i_mode_set && !i_mode_clr
		|=> o_alt_bank_select == $past(i_msr_wdata[BANK_BIT], 2))
		else $error("general mode write bank delay wrong");
	cond_false_a: assert property (@(posedge i_clk) disable iff (i_srst)
		i_cmp_we && i_cond && !i_cond_true |-> !cmp_we_eff)
		else $error("failed condition still wrote result");
	dual_dst_a: assert property (@(posedge i_clk) disable iff (i_srst)
		i_dual && i_dm_en && i_dm_ld && (i_dm_reg > R_OPND_LAST) |=> o_op_err)
		else $error("illegal dual read target not flagged");
	store_valid_a: assert property (@(posedge i_clk) disable iff (i_srst)
		i_dm_en && !i_dm_ld |=> o_dm_valid && (o_data_memory_bus == $past(dm_st_data)))
		else $error("data bus store word missing");
	feedback_err_a: assert property (@(posedge i_clk) disable iff (i_srst)
		i_cmp_we && (i_unit != UNIT_SHIFT) && (i_xsel == R_SHIFT_RESULT_UPPER) |=> o_op_err)
		else $error("upper shift word fed back unflagged");
endmodule

// *** tb/dsprf_bus_model.sv ***
`timescale 1ns/1ns
module dsprf_bus_model
	import dsprf_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_dm_rd,
	input wire logic i_pm_rd,
	input wire logic [DW-1:0] i_dm_val,
	input wire logic [DW-1:0] i_pm_val,
	input wire logic i_dm_vld,
	input wire logic [DW-1:0] i_dm_wr,
	output logic [DW-1:0] o_dm_bus,
	output logic [DW-1:0] o_pm_bus,
	output logic [DW-1:0] o_dm_seen
);
	// One word per bus per cycle; an idle bus shows inverted data
	assign o_dm_bus = i_dm_rd ? i_dm_val : ~i_dm_val;
	assign o_pm_bus = i_pm_rd ? i_pm_val : ~i_pm_val;
	always @(posedge i_clk) if (i_dm_vld) o_dm_seen <= i_dm_wr;
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ns
module testbench;
	import dsprf_pkg::*;
	logic clk = 0, rst = 1, mwe = 0, mset = 0, mclr = 0, cwe = 0, cnd = 0, ct = 0, mul = 0;
	logic dual = 0, den = 0, dld = 0, pen = 0, pld = 0, mov = 0, bank, dv, pv, err;
	logic [6:0] mwd = 0, mmask = 0, msr;
	dsprf_unit_t unit = UNIT_ALU;
	logic [3:0] xs = 0, ys = 2, cd = 0, md = 0, ms = 0, dr = 0, pr = 0;
	logic [15:0] cdat = 0, dval = 0, pval = 0, xo, yo, dbo, dbi, pbi, pbo, seen;
	int err_total = 0, checks = 0, i;
	always #20 clk = ~clk;
	dsprf_top dut_u (.i_clk(clk), .i_srst(rst), .i_msr_we(mwe), .i_msr_wdata(mwd),
		.i_mode_set(mset), .i_mode_clr(mclr), .i_mode_mask(mmask), .o_mode_status_reg(msr),
		.o_alt_bank_select(bank), .i_cmp_we(cwe), .i_unit(unit), .i_cond(cnd),
		.i_cond_true(ct), .i_multi(mul), .i_xsel(xs), .i_ysel(ys), .i_cmp_dst(cd),
		.i_cmp_data(cdat), .o_xop(xo), .o_yop(yo), .i_mov_en(mov), .i_mov_dst(md),
		.i_mov_src(ms), .i_dual(dual), .i_dm_en(den), .i_dm_ld(dld), .i_dm_reg(dr),
		.i_data_memory_bus(dbi), .o_data_memory_bus(dbo), .o_dm_valid(dv), .i_pm_en(pen),
		.i_pm_ld(pld), .i_pm_reg(pr), .i_program_memory_bus(pbi),
		.o_program_memory_bus(pbo), .o_pm_valid(pv), .o_op_err(err));
	dsprf_bus_model bus_u (.i_clk(clk), .i_dm_rd(den & dld), .i_pm_rd(pen & pld),
		.i_dm_val(dval), .i_pm_val(pval), .i_dm_vld(dv), .i_dm_wr(dbo),
		.o_dm_bus(dbi), .o_pm_bus(pbi), .o_dm_seen(seen));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic go;
		@(negedge clk);
		{mwe, mset, mclr, cwe, cnd, ct, mul, dual, den, dld, pen, pld, mov} = '0;
	endtask
	task automatic dl(input logic [3:0] r, input logic [15:0] v);
		den = 1;
		dld = 1;
		dr = r;
		dval = v;
	endtask
	task automatic pl(input logic [3:0] r, input logic [15:0] v);
		pen = 1;
		pld = 1;
		pr = r;
		pval = v;
	endtask
	task automatic cw(input logic [3:0] r, input logic [15:0] v);
		cwe = 1;
		cd = r;
		cdat = v;
	endtask
	task automatic rx(input logic [3:0] r, input logic [15:0] e);
		xs = r;
		@(negedge clk);
		chk("xop", e, xo);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_load;
		dl(R_ALU_X0, 16'h1234);
		pl(R_MAC_Y1, 16'hbeef);
		go;
		rx(R_ALU_X0, 16'h1234);
		rx(R_MAC_Y1, 16'hbeef);
	endtask
	task automatic t_prec;
		dl(R_ALU_X1, 16'ha5a5);
		cw(R_ALU_X1, 16'h0f0f);
		go;
		rx(R_ALU_X1, 16'ha5a5);
		mov = 1;
		md = R_ALU_Y1;
		ms = R_ALU_X0;
		cw(R_ALU_Y1, 16'h5555);
		go;
		rx(R_ALU_Y1, 16'h1234);
	endtask
	task automatic t_rmw;
		cw(R_ALU_X0, 16'h4321);
		rx(R_ALU_X0, 16'h1234);
		go;
		rx(R_ALU_X0, 16'h4321);
	endtask
	task automatic t_cond;
		cnd = 1;
		cw(R_ALU_X0, 16'h9999);
		go;
		rx(R_ALU_X0, 16'h4321);
		cnd = 1;
		ct = 1;
		cw(R_ALU_X0, 16'h9999);
		go;
		rx(R_ALU_X0, 16'h9999);
	endtask
	task automatic t_bank;
		mset = 1;
		mmask = 7'h01;
		go;
		chk("bank", 1, bank);
		dl(R_ALU_X0, 16'h7777);
		go;
		rx(R_ALU_X0, 16'h7777);
		mclr = 1;
		go;
		rx(R_ALU_X0, 16'h9999);
	endtask
	task automatic t_msr;
		mwe = 1;
		mwd = 7'h01;
		go;
		rx(R_ALU_X0, 16'h9999);
		go;
		rx(R_ALU_X0, 16'h7777);
		mwe = 1;
		mwd = 7'h00;
		go;
		go;
	endtask
	task automatic t_ops;
		cw(R_SHIFT_IN, 16'h0001);
		rx(R_MAC_Y0, 16'h0000);
		chk("err", 0, err);
		mul = 1;
		rx(R_MAC_Y0, 16'h0000);
		chk("err", 1, err);
		mul = 0;
		rx(R_SHIFT_RESULT_UPPER, 16'h0000);
		chk("err", 1, err);
		unit = UNIT_SHIFT;
		rx(R_SHIFT_RESULT_UPPER, 16'h0000);
		chk("err", 0, err);
		unit = UNIT_MAC;
		mul = 1;
		rx(R_MAC_X0, 16'h0000);
		chk("err", 1, err);
		unit = UNIT_ALU;
		go;
		rx(R_SHIFT_IN, 16'h0001);
	endtask
	task automatic t_dual;
		dual = 1;
		dl(R_MAC_X0, 16'h1111);
		pl(R_ALU_Y0, 16'h2222);
		go;
		rx(R_MAC_X0, 16'h1111);
		chk("yop", 16'h2222, yo);
		rx(R_ALU_Y0, 16'h2222);
		dual = 1;
		dl(R_MAC_R0, 16'h3333);
		rx(R_MAC_R0, 16'h0000);
		chk("err", 1, err);
		go;
	endtask
	task automatic t_store;
		den = 1;
		dr = R_MAC_X0;
		pen = 1;
		pr = R_ALU_Y0;
		cw(R_ALU_RES, 16'h0abc);
		#1;
		for (i = 0; i < 4 && dv !== 1'b1; i++) @(negedge clk);
		chk("dvalid", 1, dv);
		chk("dbus", 16'h1111, dbo);
		chk("pvalid", 1, pv);
		chk("pbus", 16'h2222, pbo);
		if (dv !== 1'b1) finish_test;
		go;
		chk("seen", 16'h1111, seen);
		rx(R_ALU_RES, 16'h0abc);
	endtask
	initial begin
		#200000;
		err_total++;
		finish_test;
	end
	initial begin
		repeat (12) @(negedge clk);
		rst = 0;
		#1;
		chk("bank", 0, bank);
		chk("msr", MSR_RST, msr);
		t_load;
		t_prec;
		t_rmw;
		t_cond;
		t_bank;
		t_msr;
		t_ops;
		t_dual;
		t_store;
		finish_test;
	end
endmodule
